// ==== pmst_pkg.sv ====
// constants and carrier types for the maker status and telemetry block
package pmst_pkg;

  // ----------------------------------------
  // command codes
  // ----------------------------------------
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_PHASE = 8'h04;
  localparam logic [7:0] CMD_ALERT_MASK = 8'h1B;
  localparam logic [7:0] CMD_STATUS_BYTE = 8'h78;
  localparam logic [7:0] CMD_STATUS_CML = 8'h7E;
  localparam logic [7:0] CMD_STATUS_MFR = 8'h80;
  localparam logic [7:0] CMD_INPUT_VOLTAGE_READING = 8'h88;
  localparam logic [7:0] CMD_OUTPUT_VOLTAGE_READING = 8'h8B;
  localparam logic [7:0] CMD_OUTPUT_CURRENT_READING = 8'h8C;

  // ----------------------------------------
  // field layouts and reset values
  // ----------------------------------------
  localparam int MFR_POR_BIT = 7;
  localparam int MFR_SELF_BIT = 6;
  localparam int MFR_RESET_BIT = 3;
  localparam int MFR_BCX_BIT = 2;
  localparam int MFR_SYNC_BIT = 1;
  localparam logic [7:0] MFR_LATCH_MASK = 8'h8E;
  localparam logic [7:0] MFR_SELF_MASK = 8'h40;
  localparam logic [7:0] MFR_READ_MASK = 8'hCE;
  localparam int CML_IVC_BIT = 7;
  localparam logic [7:0] CML_IVC_MASK = 8'h80;
  localparam logic [7:0] SB_CML_MASK = 8'h02;
  localparam logic [7:0] SB_MFR_MASK = 8'h01;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [7:0] PHASE_ALL = 8'hFF;
  localparam logic [7:0] PHASE_RESET = 8'hFF;
  localparam logic [15:0] ALERT_MASK_RESET = 16'h0000;
  localparam int PHASE_COUNT = 4;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned REFRESH_US = 1000;
  localparam int unsigned REFRESH_CYCLES = (CLK_HZ / 1_000_000) * REFRESH_US;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic [4:0] exponent;
    logic [10:0] mantissa;
  } pmst_linear_type;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] code;
    logic [15:0] data;
  } pmst_cmd_type;

  typedef struct packed {
    logic trim_check_bad;
    logic nvm_checksum_bad;
    logic pin_detect_bad;
    logic vout_reset;
    logic back_channel_fault;
    logic sync_fault;
  } pmst_event_type;

endpackage

// ==== pmst_tick_divider.sv ====
// divider giving one enable pulse per telemetry refresh period
`timescale 1ns/1ps
module pmst_tick_divider #(
  parameter int unsigned PERIOD = pmst_pkg::REFRESH_CYCLES
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // enable
  output logic tick_out
);

  localparam int W = (PERIOD > 1) ? $clog2(PERIOD) : 1;
  localparam logic [W-1:0] LAST = W'(PERIOD - 1);

  logic [W-1:0] count_reg;

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      count_reg <= '0;
    end else if (count_reg == LAST) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_reg + W'(1);
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      tick_out <= 1'b0;
    end else begin
      tick_out <= (count_reg == LAST);
    end
  end

endmodule

// ==== pmst_mfr_status_telemetry.sv ====
// maker fault status byte, communication fault flag and telemetry readings
//
// Functional notes
// - latch power-on fault when trim, store checksum or pin detection check fails
// - self-check bit is live: busy or any expected follower silent
// - status bits 5:4 and 0 always read zero
// - latch bit 3 on an output-voltage reset event
// - latch bit 2 on a back-channel fault event
// - latch bit 1 on a sync fault
// - writing one clears a set status bit; zero leaves it
// - every alerting status bit has a mask bit suppressing its alert
// - input voltage and current are linear words, 5-bit exponent, 11-bit mantissa
// - input voltage refreshed every millisecond, 0 to 24 volts
// - phase all-ones returns the stack master's input voltage
// - phases 0 to 3 return that phase's input voltage; any other phase reads zero
// - writes to read-only telemetry set invalid-command, summary bit, notify host
// - output voltage reading is a 16-bit unsigned word in mode format
// - output voltage refreshed every millisecond, 0 to 6 volts
// - follower mode reports raw sense pin; host keeps it below 0.75 V
// - output current refreshed every millisecond, -15 to 90 A per phase
// - phase all-ones returns summed stack current
// - phases 0 to 3 return that phase's measured current; any other phase reads zero
// - summary bit is OR of latched flags, clearing with them
// - clear-faults command clears all latched maker status bits
`timescale 1ns/1ps
module pmst_mfr_status_telemetry #(
  parameter int unsigned REFRESH_CYCLES = pmst_pkg::REFRESH_CYCLES
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // command port from the bus engine
  input wire pmst_pkg::pmst_cmd_type cmd_in,
  output logic rd_valid_out,
  output logic [15:0] rd_data_out,
  output logic cmd_reject_out,
  // fault events and self-check
  input wire pmst_pkg::pmst_event_type events_in,
  input wire logic selfcheck_busy_in,
  input wire logic [pmst_pkg::PHASE_COUNT-1:0] follower_expected_in,
  input wire logic [pmst_pkg::PHASE_COUNT-1:0] follower_answered_in,
  // measurements from the front end
  input wire pmst_pkg::pmst_linear_type vin_master_in,
  input wire pmst_pkg::pmst_linear_type [pmst_pkg::PHASE_COUNT-1:0] vin_phase_in,
  input wire pmst_pkg::pmst_linear_type iout_total_in,
  input wire pmst_pkg::pmst_linear_type [pmst_pkg::PHASE_COUNT-1:0] iout_phase_in,
  input wire logic [15:0] vout_scaled_in,
  input wire logic [15:0] vout_sense_in,
  input wire logic sense_ground_on_bias_in,
  // status to the host side
  output logic alert_out,
  output logic [7:0] status_byte_out
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // an out-of-range phase reads as zero rather than aliasing another phase
  function automatic logic [15:0] pick_phase(
    input pmst_pkg::pmst_linear_type [pmst_pkg::PHASE_COUNT-1:0] arr,
    input pmst_pkg::pmst_linear_type all_value,
    input logic [7:0] phase
  );
    logic [15:0] r;
    r = pmst_pkg::WORD_ZERO;
    if (phase == pmst_pkg::PHASE_ALL) begin
      r = all_value;
    end else begin
      for (int i = 0; i < pmst_pkg::PHASE_COUNT; i++) begin
        if (phase == 8'(i)) begin
          r = arr[i];
        end
      end
    end
    return r;
  endfunction

  function automatic logic is_read_only(input logic [7:0] code);
    return (code == pmst_pkg::CMD_INPUT_VOLTAGE_READING) || (code == pmst_pkg::CMD_OUTPUT_VOLTAGE_READING) ||
           (code == pmst_pkg::CMD_OUTPUT_CURRENT_READING);
  endfunction

  // ----------------------------------------
  // command decode
  // ----------------------------------------
  logic wr;
  logic rd;
  logic clear_all;
  logic ro_write;
  assign wr = cmd_in.valid && cmd_in.write;
  assign rd = cmd_in.valid && !cmd_in.write;
  assign clear_all = wr && (cmd_in.code == pmst_pkg::CMD_CLEAR_FAULTS);
  assign ro_write = wr && is_read_only(cmd_in.code);

  // ----------------------------------------
  // maker status byte
  // ----------------------------------------
  logic [7:0] mfr_reg;
  logic [7:0] mfr_set;
  logic [7:0] mfr_clear;
  logic [7:0] mfr_view;
  logic self_live;

  always_comb begin
    mfr_set = pmst_pkg::BYTE_ZERO;
    mfr_set[pmst_pkg::MFR_POR_BIT] = events_in.trim_check_bad || events_in.nvm_checksum_bad ||
                                     events_in.pin_detect_bad;
    mfr_set[pmst_pkg::MFR_RESET_BIT] = events_in.vout_reset;
    mfr_set[pmst_pkg::MFR_BCX_BIT] = events_in.back_channel_fault;
    mfr_set[pmst_pkg::MFR_SYNC_BIT] = events_in.sync_fault;
  end

  always_comb begin
    mfr_clear = pmst_pkg::BYTE_ZERO;
    if (wr && (cmd_in.code == pmst_pkg::CMD_STATUS_MFR)) begin
      mfr_clear = cmd_in.data[7:0] & pmst_pkg::MFR_LATCH_MASK;
    end
    if (clear_all) begin
      mfr_clear = pmst_pkg::MFR_LATCH_MASK;
    end
  end

  // set wins over a clear landing in the same cycle
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      mfr_reg <= pmst_pkg::BYTE_ZERO;
    end else begin
      mfr_reg <= ((mfr_reg & ~mfr_clear) | mfr_set) & pmst_pkg::MFR_LATCH_MASK;
    end
  end

  assign self_live = selfcheck_busy_in ||
                     (|(follower_expected_in & ~follower_answered_in));
  assign mfr_view = (mfr_reg & pmst_pkg::MFR_LATCH_MASK) |
                    (self_live ? pmst_pkg::MFR_SELF_MASK : pmst_pkg::BYTE_ZERO);

  // ----------------------------------------
  // communication fault flag
  // ----------------------------------------
  logic ivc_reg;
  logic ivc_clear;
  assign ivc_clear = clear_all || (wr && (cmd_in.code == pmst_pkg::CMD_STATUS_CML) &&
                     cmd_in.data[pmst_pkg::CML_IVC_BIT]);

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      ivc_reg <= 1'b0;
    end else if (ro_write) begin
      ivc_reg <= 1'b1;
    end else if (ivc_clear) begin
      ivc_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      cmd_reject_out <= 1'b0;
    end else begin
      cmd_reject_out <= ro_write;
    end
  end

  // ----------------------------------------
  // phase, alert mask and summary
  // ----------------------------------------
  logic [7:0] phase_reg;
  logic [15:0] alert_mask_reg;
  logic [7:0] status_byte;

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      phase_reg <= pmst_pkg::PHASE_RESET;
    end else if (wr && (cmd_in.code == pmst_pkg::CMD_PHASE)) begin
      phase_reg <= cmd_in.data[7:0];
    end
  end

  // upper byte masks the communication flags, lower byte the maker flags
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      alert_mask_reg <= pmst_pkg::ALERT_MASK_RESET;
    end else if (wr && (cmd_in.code == pmst_pkg::CMD_ALERT_MASK)) begin
      alert_mask_reg <= cmd_in.data;
    end
  end

  always_comb begin
    status_byte = pmst_pkg::BYTE_ZERO;
    if (ivc_reg) begin
      status_byte = status_byte | pmst_pkg::SB_CML_MASK;
    end
    if (|mfr_reg) begin
      status_byte = status_byte | pmst_pkg::SB_MFR_MASK;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      status_byte_out <= pmst_pkg::BYTE_ZERO;
    end else begin
      status_byte_out <= status_byte;
    end
  end

  // the live self-check bit does not alert; it would fire at every power-up
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      alert_out <= 1'b0;
    end else begin
      alert_out <= (|(mfr_reg & ~alert_mask_reg[7:0])) ||
                   (ivc_reg && !alert_mask_reg[8 + pmst_pkg::CML_IVC_BIT]);
    end
  end

  // ----------------------------------------
  // telemetry snapshots
  // ----------------------------------------
  logic refresh_tick;
  pmst_pkg::pmst_linear_type vin_master_reg;
  pmst_pkg::pmst_linear_type iout_total_reg;
  pmst_pkg::pmst_linear_type [pmst_pkg::PHASE_COUNT-1:0] vin_phase_reg;
  pmst_pkg::pmst_linear_type [pmst_pkg::PHASE_COUNT-1:0] iout_phase_reg;
  logic [15:0] vout_reg;

  pmst_tick_divider #(.PERIOD(REFRESH_CYCLES)) refresh_div (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .tick_out(refresh_tick)
  );

  // all phases are held so a phase change reads valid data at once
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      vin_master_reg <= '0;
      vin_phase_reg <= '0;
      iout_total_reg <= '0;
      iout_phase_reg <= '0;
    end else if (refresh_tick) begin
      vin_master_reg <= vin_master_in;
      vin_phase_reg <= vin_phase_in;
      iout_total_reg <= iout_total_in;
      iout_phase_reg <= iout_phase_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      vout_reg <= pmst_pkg::WORD_ZERO;
    end else if (refresh_tick) begin
      vout_reg <= sense_ground_on_bias_in ? vout_sense_in : vout_scaled_in;
    end
  end

  // ----------------------------------------
  // read answer
  // ----------------------------------------
  logic [15:0] rd_word;
  always_comb begin
    rd_word = pmst_pkg::WORD_ZERO;
    unique case (cmd_in.code)
      pmst_pkg::CMD_STATUS_MFR: rd_word = {pmst_pkg::BYTE_ZERO, mfr_view};
      pmst_pkg::CMD_STATUS_CML: rd_word = {pmst_pkg::BYTE_ZERO,
                                           ivc_reg ? pmst_pkg::CML_IVC_MASK : pmst_pkg::BYTE_ZERO};
      pmst_pkg::CMD_STATUS_BYTE: rd_word = {pmst_pkg::BYTE_ZERO, status_byte};
      pmst_pkg::CMD_PHASE: rd_word = {pmst_pkg::BYTE_ZERO, phase_reg};
      pmst_pkg::CMD_ALERT_MASK: rd_word = alert_mask_reg;
      pmst_pkg::CMD_INPUT_VOLTAGE_READING: rd_word = pick_phase(vin_phase_reg, vin_master_reg, phase_reg);
      pmst_pkg::CMD_OUTPUT_VOLTAGE_READING: rd_word = vout_reg;
      pmst_pkg::CMD_OUTPUT_CURRENT_READING: rd_word = pick_phase(iout_phase_reg, iout_total_reg, phase_reg);
      default: rd_word = pmst_pkg::WORD_ZERO;
    endcase
  end

  // whole word taken in one edge, so both bytes share one update
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      rd_valid_out <= 1'b0;
      rd_data_out <= pmst_pkg::WORD_ZERO;
    end else begin
      rd_valid_out <= rd;
      if (rd) begin
        rd_data_out <= rd_word;
      end
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  AST_POR_LATCH: assert property ((events_in.trim_check_bad || events_in.nvm_checksum_bad ||
    events_in.pin_detect_bad) |=>
    mfr_reg[pmst_pkg::MFR_POR_BIT]) else $error("por flag not latched");
  AST_SELF_LIVE: assert property ((selfcheck_busy_in ||
    |(follower_expected_in & ~follower_answered_in)) == mfr_view[pmst_pkg::MFR_SELF_BIT])
    else $error("self-check bit wrong");
  AST_ZERO_BITS: assert property ((mfr_view & ~pmst_pkg::MFR_READ_MASK) == pmst_pkg::BYTE_ZERO)
    else $error("unsupported bit set");
  AST_RESET_LATCH: assert property (events_in.vout_reset |=> mfr_reg[pmst_pkg::MFR_RESET_BIT])
    else $error("reset flag not latched");
  AST_BCX_HOLD: assert property (mfr_reg[pmst_pkg::MFR_BCX_BIT] && !clear_all &&
    !(wr && cmd_in.code == pmst_pkg::CMD_STATUS_MFR) |=> mfr_reg[pmst_pkg::MFR_BCX_BIT])
    else $error("back-channel flag lost");
  AST_SYNC_LATCH: assert property (events_in.sync_fault |=> mfr_reg[pmst_pkg::MFR_SYNC_BIT])
    else $error("sync flag not latched");
  AST_W1C: assert property (wr && cmd_in.code == pmst_pkg::CMD_STATUS_MFR &&
    cmd_in.data[pmst_pkg::MFR_SYNC_BIT] && !events_in.sync_fault |=>
    !mfr_reg[pmst_pkg::MFR_SYNC_BIT]) else $error("write one did not clear");
  AST_MASKED: assert property (alert_mask_reg == 16'hFFFF [*2] |-> !alert_out)
    else $error("masked flag raised alert");
  AST_IVC: assert property (ro_write |=> ivc_reg && cmd_reject_out ##1 status_byte_out[1])
    else $error("read-only write not flagged");
  AST_VIN_ALL: assert property (rd && cmd_in.code == pmst_pkg::CMD_INPUT_VOLTAGE_READING &&
    phase_reg == pmst_pkg::PHASE_ALL |=> rd_valid_out && rd_data_out == $past(vin_master_reg))
    else $error("wrong stack input voltage");
  AST_REFRESH: assert property (refresh_tick |=> iout_total_reg == $past(iout_total_in))
    else $error("current not refreshed");
  AST_CLEAR: assert property (clear_all && !(|mfr_set) |=> mfr_reg == pmst_pkg::BYTE_ZERO && !ivc_reg)
    else $error("clear faults incomplete");
  AST_FOLLOWER: assert property (refresh_tick && sense_ground_on_bias_in |=>
    vout_reg == $past(vout_sense_in)) else $error("follower vout wrong");

  COV_IVC: cover property (ro_write ##1 alert_out);
  COV_PHASE_READ: cover property (rd && cmd_in.code == pmst_pkg::CMD_OUTPUT_CURRENT_READING &&
    phase_reg != pmst_pkg::PHASE_ALL);
  COV_SET_CLEAR: cover property (events_in.sync_fault && clear_all);

endmodule

// ==== pmst_stack_model.sv ====
// behavioural model of the stacked converters and analog front end feeding the telemetry
`timescale 1ns/1ps
module pmst_stack_model (
  // stimulus
  input wire logic [10:0] base_in,
  // measurements
  output pmst_pkg::pmst_linear_type vin_master_out,
  output pmst_pkg::pmst_linear_type [pmst_pkg::PHASE_COUNT-1:0] vin_phase_out,
  output pmst_pkg::pmst_linear_type iout_total_out,
  output pmst_pkg::pmst_linear_type [pmst_pkg::PHASE_COUNT-1:0] iout_phase_out,
  output logic [15:0] vout_scaled_out,
  output logic [15:0] vout_sense_out
);
  // ----------------------------------------
  // front end values
  // ----------------------------------------
  // one shared exponent so the stack sum stays a plain mantissa add
  localparam logic [4:0] EXP = 5'h1E;
  logic [10:0] sum;
  always_comb begin
    sum = 11'h000;
    for (int i = 0; i < pmst_pkg::PHASE_COUNT; i++) begin
      vin_phase_out[i] = {EXP, base_in + 11'(i)};
      iout_phase_out[i] = {EXP, base_in + 11'(2 * i)};
      sum = sum + base_in + 11'(2 * i);
    end
    vin_master_out = {EXP, base_in + 11'h020};
    iout_total_out = {EXP, sum};
    vout_scaled_out = {5'h00, base_in};
    // sense input kept in the low range a follower may present
    vout_sense_out = {8'h00, base_in[7:0]};
  end
endmodule

// ==== pmbus_mfr_status_telemetry_tb_top.sv ====
// self-checking testbench for the maker status and telemetry block
`timescale 1ns/1ps
module pmbus_mfr_status_telemetry_tb_top;
  localparam int RC = 8;
  localparam logic [4:0] EXP = 5'h1E;
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  pmst_pkg::pmst_cmd_type cmd_in = '0;
  pmst_pkg::pmst_event_type events_in = '0;
  logic selfcheck_busy_in = 1'b0;
  logic [3:0] follower_expected_in = 4'h0;
  logic [3:0] follower_answered_in = 4'h0;
  logic sense_ground_on_bias_in = 1'b0;
  logic [10:0] base = 11'h010;
  pmst_pkg::pmst_linear_type vin_master, iout_total;
  pmst_pkg::pmst_linear_type [3:0] vin_phase, iout_phase;
  logic [15:0] vout_scaled, vout_sense, rd_data_out;
  logic rd_valid_out, cmd_reject_out, alert_out;
  logic [7:0] status_byte_out;
  logic [7:0] ebit [6] = '{8'h80, 8'h80, 8'h80, 8'h08, 8'h04, 8'h02};
  logic [7:0] tcode [3] = '{pmst_pkg::CMD_INPUT_VOLTAGE_READING, pmst_pkg::CMD_OUTPUT_VOLTAGE_READING,
    pmst_pkg::CMD_OUTPUT_CURRENT_READING};
  int fails = 0;
  int compares = 0;

  // ----------------------------------------
  // instances
  // ----------------------------------------
  pmst_stack_model u_stack (.base_in(base), .vin_master_out(vin_master),
    .vin_phase_out(vin_phase), .iout_total_out(iout_total), .iout_phase_out(iout_phase),
    .vout_scaled_out(vout_scaled), .vout_sense_out(vout_sense));
  pmst_mfr_status_telemetry #(.REFRESH_CYCLES(RC)) u_dut (.clk_in(clk_in),
    .reset_n_in(reset_n_in), .cmd_in(cmd_in), .rd_valid_out(rd_valid_out),
    .rd_data_out(rd_data_out), .cmd_reject_out(cmd_reject_out), .events_in(events_in),
    .selfcheck_busy_in(selfcheck_busy_in), .follower_expected_in(follower_expected_in),
    .follower_answered_in(follower_answered_in), .vin_master_in(vin_master),
    .vin_phase_in(vin_phase), .iout_total_in(iout_total), .iout_phase_in(iout_phase),
    .vout_scaled_in(vout_scaled), .vout_sense_in(vout_sense),
    .sense_ground_on_bias_in(sense_ground_on_bias_in), .alert_out(alert_out),
    .status_byte_out(status_byte_out));

  initial begin
    forever #12.5 clk_in = ~clk_in;
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  // command is a one-cycle pulse; outputs are looked at one cycle on
  task automatic send(input logic w, input logic [7:0] code, input logic [15:0] data);
    @(negedge clk_in);
    cmd_in = {1'b1, w, code, data};
    @(negedge clk_in);
    cmd_in = '0;
  endtask
  task automatic rd(input logic [7:0] code, input logic [15:0] exp);
    send(1'b0, code, 16'h0000);
    check({15'h0000, rd_valid_out}, 16'h0001);
    check(rd_data_out, exp);
  endtask
  task automatic wr(input logic [7:0] code, input logic [15:0] data, input logic rej);
    send(1'b1, code, data);
    check({15'h0000, cmd_reject_out}, {15'h0000, rej});
  endtask
  task automatic stat(input logic [7:0] sb, input logic al);
    check({7'h00, alert_out, status_byte_out}, {7'h00, al, sb});
  endtask
  task automatic pulse(input logic [5:0] e);
    @(negedge clk_in);
    events_in = e;
    @(negedge clk_in);
    events_in = '0;
  endtask
  task automatic conclude();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    #(25 * 5000);
    fails++;
    conclude();
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (3) @(negedge clk_in);
    reset_n_in = 1'b1;
    stat(8'h00, 1'b0);
    rd(pmst_pkg::CMD_STATUS_MFR, 16'h0000);
    rd(pmst_pkg::CMD_INPUT_VOLTAGE_READING, 16'h0000);
    selfcheck_busy_in = 1'b1;
    rd(pmst_pkg::CMD_STATUS_MFR, 16'h0040);
    stat(8'h00, 1'b0);
    selfcheck_busy_in = 1'b0;
    follower_expected_in = 4'h3;
    follower_answered_in = 4'h1;
    rd(pmst_pkg::CMD_STATUS_MFR, 16'h0040);
    follower_answered_in = 4'h3;
    rd(pmst_pkg::CMD_STATUS_MFR, 16'h0000);
    for (int i = 0; i < 6; i++) begin
      pulse(6'h20 >> i);
      rd(pmst_pkg::CMD_STATUS_MFR, {8'h00, ebit[i]});
      stat(8'h01, 1'b1);
      wr(pmst_pkg::CMD_STATUS_MFR, {8'h00, ~ebit[i]}, 1'b0);
      rd(pmst_pkg::CMD_STATUS_MFR, {8'h00, ebit[i]});
      wr(pmst_pkg::CMD_STATUS_MFR, 16'h00FF, 1'b0);
      rd(pmst_pkg::CMD_STATUS_MFR, 16'h0000);
      stat(8'h00, 1'b0);
    end
    pulse(6'h3F);
    rd(pmst_pkg::CMD_STATUS_MFR, 16'h008E);
    wr(pmst_pkg::CMD_CLEAR_FAULTS, 16'h0000, 1'b0);
    rd(pmst_pkg::CMD_STATUS_MFR, 16'h0000);
    wr(pmst_pkg::CMD_ALERT_MASK, 16'h0002, 1'b0);
    pulse(6'h01);
    rd(pmst_pkg::CMD_STATUS_MFR, 16'h0002);
    stat(8'h01, 1'b0);
    wr(pmst_pkg::CMD_ALERT_MASK, 16'h8000, 1'b0);
    cyc(1);
    stat(8'h01, 1'b1);
    wr(pmst_pkg::CMD_STATUS_MFR, 16'h0002, 1'b0);
    wr(pmst_pkg::CMD_INPUT_VOLTAGE_READING, 16'h1234, 1'b1);
    cyc(1);
    stat(8'h02, 1'b0);
    wr(pmst_pkg::CMD_STATUS_CML, 16'h0080, 1'b0);
    wr(pmst_pkg::CMD_ALERT_MASK, 16'h0000, 1'b0);
    for (int i = 0; i < 3; i++) begin
      wr(tcode[i], 16'h1234, 1'b1);
      cyc(1);
      stat(8'h02, 1'b1);
      rd(pmst_pkg::CMD_STATUS_CML, 16'h0080);
      wr(pmst_pkg::CMD_STATUS_CML, 16'h0080, 1'b0);
      rd(pmst_pkg::CMD_STATUS_CML, 16'h0000);
      stat(8'h00, 1'b0);
    end
    // a full refresh period plus margin guarantees one snapshot
    cyc(RC + 2);
    rd(pmst_pkg::CMD_INPUT_VOLTAGE_READING, {EXP, base + 11'h020});
    rd(pmst_pkg::CMD_OUTPUT_CURRENT_READING, {EXP, 11'(4 * base + 11'h00C)});
    rd(pmst_pkg::CMD_OUTPUT_VOLTAGE_READING, {5'h00, base});
    for (int p = 0; p < 4; p++) begin
      wr(pmst_pkg::CMD_PHASE, 16'(p), 1'b0);
      rd(pmst_pkg::CMD_INPUT_VOLTAGE_READING, {EXP, base + 11'(p)});
      rd(pmst_pkg::CMD_OUTPUT_CURRENT_READING, {EXP, base + 11'(2 * p)});
    end
    wr(pmst_pkg::CMD_PHASE, 16'h0005, 1'b0);
    rd(pmst_pkg::CMD_INPUT_VOLTAGE_READING, 16'h0000);
    wr(pmst_pkg::CMD_PHASE, 16'h00FF, 1'b0);
    sense_ground_on_bias_in = 1'b1;
    base = 11'h05A;
    cyc(RC + 2);
    rd(pmst_pkg::CMD_OUTPUT_VOLTAGE_READING, 16'h005A);
    rd(pmst_pkg::CMD_INPUT_VOLTAGE_READING, {EXP, 11'h07A});
    rd(pmst_pkg::CMD_OUTPUT_CURRENT_READING, {EXP, 11'h174});
    // every mask bit set: a latched flag must stay silent
    wr(pmst_pkg::CMD_ALERT_MASK, 16'hFFFF, 1'b0);
    pulse(6'h01);
    cyc(1);
    stat(8'h01, 1'b0);
    wr(pmst_pkg::CMD_CLEAR_FAULTS, 16'h0000, 1'b0);
    cyc(1);
    stat(8'h00, 1'b0);
    conclude();
  end
endmodule
